// ---- hdl/ssr_pkg.sv ----
// Package for the scale status register group: offsets, field positions, types.
// Assumes a single 100 MHz clock domain and a simple synchronous read port.
package ssr_pkg;

   // Register word indices on the read port
   localparam logic [3:0] SSR_IDX_INST_STATUS = 4'h0;
   localparam logic [3:0] SSR_IDX_SCALE_ERROR = 4'h1;
   localparam logic [3:0] SSR_IDX_SCALE_STATUS = 4'h2;
   localparam logic [3:0] SSR_IDX_INST_STATE = 4'h3;
   localparam logic [3:0] SSR_IDX_GROSS = 4'h4;
   localparam logic [3:0] SSR_IDX_NET = 4'h5;
   localparam logic [3:0] SSR_IDX_FLOW = 4'h6;
   localparam logic [3:0] SSR_IDX_INPUT_SIG = 4'h7;

   // Instrument status word fields
   localparam int SSR_IS_REMOTE_BIT = 0;
   localparam int SSR_IS_RESTART_BIT = 1;

   // Scale status word fields
   localparam int SSR_SS_NET_OVF_BIT = 0;
   localparam int SSR_SS_GROSS_OVF_BIT = 1;
   localparam int SSR_SS_FLOW_OVF_BIT = 2;
   localparam int SSR_SS_ZERO_DISP_BIT = 3;
   localparam int SSR_SS_ZERO_GROSS_BIT = 4;
   localparam int SSR_SS_ZERO_NET_BIT = 5;
   localparam int SSR_SS_NET_MODE_BIT = 6;
   localparam int SSR_SS_MOTION_BIT = 7;
   localparam int SSR_SS_FLOW_DISP_BIT = 11;
   localparam int SSR_SS_NET_PREC_BIT = 12;
   localparam int SSR_SS_GROSS_PREC_BIT = 13;

   // Scaled-integer range of one signed 16-bit register
   localparam logic signed [31:0] SSR_INT_MAX = 32'sh0000_7FFF;
   localparam logic signed [31:0] SSR_INT_MIN = -32'sh0000_8000;
   // Six-digit magnitude limit
   localparam logic signed [31:0] SSR_DIGIT6_MAX = 32'sd999999;

   // Reset values
   localparam logic [7:0] SSR_ERR_RESET = 8'h00;
   localparam logic [15:0] SSR_WORD_RESET = 16'h0000;
   localparam logic [31:0] SSR_WIDE_RESET = 32'h0000_0000;

   // Instrument state codes
   typedef enum logic [2:0] {
      SSR_ST_STARTING = 3'h0,
      SSR_ST_WAIT_START = 3'h1,
      SSR_ST_WARMUP = 3'h2,
      SSR_ST_NORMAL = 3'h3,
      SSR_ST_ERROR = 3'h4,
      SSR_ST_FATAL = 3'h5,
      SSR_ST_POWER_FAIL = 3'h6
   } ssr_state_t;

   // Source of a register read
   typedef enum logic [1:0] {
      SSR_SRC_RTU = 2'h0,
      SSR_SRC_TCP = 2'h1,
      SSR_SRC_FIELDBUS = 2'h2
   } ssr_src_t;

   // Live measurements and conditions from the weighing core
   typedef struct packed {
      logic signed [31:0] gross;
      logic signed [31:0] net;
      logic signed [31:0] flow;
      logic signed [31:0] input_uvv;
      logic [7:0] error_code;
      logic zero_disp;
      logic zero_gross;
      logic zero_net;
      logic net_mode;
      logic motion;
      logic flow_disp;
   } ssr_meas_t;

   // Read request from a communication channel
   typedef struct packed {
      logic valid;
      logic [3:0] index;
      logic float_view;
      ssr_src_t src;
   } ssr_req_t;

endpackage

// ---- hdl/ssr_status_pack.sv ----
// Combinational packer of the scale status word from live conditions.
// Assumes measurement inputs are stable in the cycle they are sampled.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_pack
   import ssr_pkg::*;
(
   input wire ssr_meas_t meas,
   input wire logic float_view,
   output logic [15:0] status_word
);

   // Does a value fit one signed 16-bit register
   function automatic logic ssr_fits_int(input logic signed [31:0] v);
      ssr_fits_int = (v <= SSR_INT_MAX) && (v >= SSR_INT_MIN);
   endfunction

   // Does a value exceed six digits in magnitude
   function automatic logic ssr_over_6dig(input logic signed [31:0] v);
      ssr_over_6dig = (v > SSR_DIGIT6_MAX) || (v < -SSR_DIGIT6_MAX);
   endfunction

   // Build the word; undefined bits stay zero
   always_comb begin
      status_word = SSR_WORD_RESET;
      status_word[SSR_SS_NET_OVF_BIT] = !float_view && !ssr_fits_int(meas.net);
      status_word[SSR_SS_GROSS_OVF_BIT] = !float_view && !ssr_fits_int(meas.gross);
      status_word[SSR_SS_FLOW_OVF_BIT] = !float_view && !ssr_fits_int(meas.flow);
      status_word[SSR_SS_ZERO_DISP_BIT] = meas.zero_disp;
      status_word[SSR_SS_ZERO_GROSS_BIT] = meas.zero_gross;
      status_word[SSR_SS_ZERO_NET_BIT] = meas.zero_net;
      status_word[SSR_SS_NET_MODE_BIT] = meas.net_mode;
      status_word[SSR_SS_MOTION_BIT] = meas.motion;
      status_word[SSR_SS_FLOW_DISP_BIT] = meas.flow_disp;
      status_word[SSR_SS_NET_PREC_BIT] = ssr_over_6dig(meas.net);
      status_word[SSR_SS_GROSS_PREC_BIT] = ssr_over_6dig(meas.gross);
   end

endmodule
`default_nettype wire

// ---- hdl/ssr_regs.sv ----
// Status and measurement register group of the weighing instrument.
// Assumes reads arrive one per cycle from a protocol engine that tags the channel.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Instrument status bit 0 shows remote operation active.
// - Restart flag sets whenever the program starts, i.e. while reset is asserted.
// - Set restart flag tells the master volatile data was lost.
// - First status read over RTU or TCP clears the restart flag.
// - The clearing read still returns the flag as set.
// - Fieldbus reads keep the flag; fieldbus clears it by a reset command.
// - Scale error code holds 0..255; zero means no error.
// - Status bits 0..2 flag net, gross, flow too large for one register.
// - Overflow bits read zero through the floating-point view.
// - Status bits 3..5 flag good zero on display, gross, net.
// - Status bit 6 is one in net mode, zero in gross mode.
// - Status bit 11 set while display shows flow rate.
// - Status bits 12, 13 flag net, gross above six digits.
// - Input signal register shows present load-cell level in uV/V.
// - Instrument state codes 00 to 06 as enumerated.
module ssr_regs
   import ssr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ssr_meas_t meas,
   input wire ssr_state_t inst_state,
   input wire logic remote_on,
   input wire logic fb_clear_restart,
   input wire ssr_req_t req,
   output logic rd_valid_ff,
   output logic [31:0] rd_data_ff,
   output logic [7:0] err_seen_ff,
   output logic restart_ff
);

   logic [15:0] scale_word;
   logic [15:0] inst_word;
   logic [31:0] nxt_rd_data;
   logic status_read_clears;
   ssr_meas_t meas_ff;

   // Measurement snapshot so one read sees one coherent set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meas_ff <= '0;
      end else begin
         meas_ff <= meas;
      end
   end

   // Scale status word packer
   ssr_status_pack u_pack (
      .meas(meas_ff),
      .float_view(req.float_view),
      .status_word(scale_word)
   );

   // Modbus channels clear the flag on a status read; fieldbus does not
   assign status_read_clears = req.valid && (req.index == SSR_IDX_INST_STATUS) &&
                               (req.src != SSR_SRC_FIELDBUS);

   // Restart flag: set by reset, cleared by first Modbus read or fieldbus command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         restart_ff <= 1'b1;
      end else if (status_read_clears || fb_clear_restart) begin
         restart_ff <= 1'b0;
      end
   end

   // Instrument status word, unused bits zero
   always_comb begin
      inst_word = SSR_WORD_RESET;
      inst_word[SSR_IS_REMOTE_BIT] = remote_on;
      inst_word[SSR_IS_RESTART_BIT] = restart_ff;
   end

   // Read multiplexer
   always_comb begin
      nxt_rd_data = SSR_WIDE_RESET;
      unique case (req.index)
         SSR_IDX_INST_STATUS: nxt_rd_data = {16'h0000, inst_word};
         SSR_IDX_SCALE_ERROR: nxt_rd_data = {24'h000000, meas_ff.error_code};
         SSR_IDX_SCALE_STATUS: nxt_rd_data = {16'h0000, scale_word};
         SSR_IDX_INST_STATE: nxt_rd_data = {29'h00000000, inst_state};
         SSR_IDX_GROSS: nxt_rd_data = meas_ff.gross;
         SSR_IDX_NET: nxt_rd_data = meas_ff.net;
         SSR_IDX_FLOW: nxt_rd_data = meas_ff.flow;
         SSR_IDX_INPUT_SIG: nxt_rd_data = meas_ff.input_uvv;
         default: nxt_rd_data = SSR_WIDE_RESET;
      endcase
   end

   // Read reply registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= SSR_WIDE_RESET;
      end else begin
         rd_valid_ff <= req.valid;
         if (req.valid) begin
            rd_data_ff <= nxt_rd_data;
         end
      end
   end

   // Error code accompanying every reply, for validity of weights
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_seen_ff <= SSR_ERR_RESET;
      end else if (req.valid) begin
         err_seen_ff <= meas_ff.error_code;
      end
   end

endmodule
`default_nettype wire

// ---- tb/ssr_regs_monitor.sv ----
// Checker for the scale status register group, bound to ssr_regs.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_monitor
   import ssr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic remote_on,
   input wire logic fb_clear_restart,
   input wire ssr_req_t req,
   input wire logic rd_valid_ff,
   input wire logic [31:0] rd_data_ff,
   input wire logic restart_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Status word and scale status reads
   wire logic st_rd = req.valid && req.index == SSR_IDX_INST_STATUS;
   wire logic ss_rd = req.valid && req.index == SSR_IDX_SCALE_STATUS;
   ans_lat_a: assert property (rd_valid_ff == $past(req.valid)) else $error("reply pulse misplaced");
   hold_data_a: assert property (!req.valid |=> $stable(rd_data_ff)) else $error("reply data moved");
   clr_link_a: assert property (st_rd && req.src != SSR_SRC_FIELDBUS |=> !restart_ff) else $error("no clear");
   reply_set_a: assert property (st_rd |=> rd_data_ff[1] == $past(restart_ff)) else $error("flag reply");
   keep_fb_a: assert property (restart_ff && !fb_clear_restart && !(st_rd && req.src != SSR_SRC_FIELDBUS)
      |=> restart_ff) else $error("flag lost");
   fb_cmd_a: assert property (fb_clear_restart |=> !restart_ff) else $error("command ignored");
   remote_bit_a: assert property (st_rd |=> rd_data_ff[0] == $past(remote_on)) else $error("remote bit");
   is_unused_a: assert property (st_rd |=> rd_data_ff[31:2] == '0) else $error("status spare bits");
   fv_ovf_a: assert property (ss_rd && req.float_view |=> rd_data_ff[2:0] == '0) else $error("float ovf");
   ss_unused_a: assert property (ss_rd |=> rd_data_ff[10:8] == '0 && rd_data_ff[31:14] == '0)
      else $error("scale spare bits");
   // Main scenarios reached
   cov_clear_c: cover property ($fell(restart_ff));
   cov_float_c: cover property (ss_rd && req.float_view);
   cov_cmd_c: cover property (fb_clear_restart && restart_ff);
endmodule
bind ssr_regs ssr_regs_monitor ssr_regs_monitor_i(.clk(clk), .rst(rst), .remote_on(remote_on),
   .fb_clear_restart(fb_clear_restart), .req(req), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff),
   .restart_ff(restart_ff));
`default_nettype wire

// ---- tb/ssr_master_model.sv ----
// Master model: one register read at a time over a chosen link.
// Assumes a reply pulse registered on the taking edge itself, visible just after it.
`timescale 1ns/1ps
`default_nettype none
module ssr_master_model
   import ssr_pkg::*;
(
   input wire logic clk,
   input wire logic rd_valid_ff,
   input wire logic [31:0] rd_data_ff,
   output var ssr_req_t req
);
   initial req = '0;
   // Weights are usable only beside a zero error code
   function automatic logic trust(input logic [7:0] err);
      return err === 8'h00;
   endfunction
   // Request held until the taking edge, reply caught just after it
   task automatic rd(input logic [3:0] idx, input ssr_src_t src, input logic fv, output logic [31:0] data);
      @(posedge clk);
      req <= '{valid: 1'b1, index: idx, float_view: fv, src: src};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      data = (rd_valid_ff === 1'b1) ? rd_data_ff : 32'hDEAD_BEEF;
   endtask
endmodule
`default_nettype wire

// ---- tb/ssr_regs_tb_top.sv ----
// Self-checking bench for the scale status register group.
// Drives conditions directly and reads through the master model.
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_tb_top;
   import ssr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic remote_on = 1'b0;
   logic fb_clear_restart = 1'b0;
   ssr_meas_t meas = '0;
   ssr_state_t inst_state = SSR_ST_STARTING;
   ssr_req_t req;
   logic rd_valid_ff;
   logic restart_ff;
   logic [31:0] rd_data_ff;
   logic [31:0] d;
   logic [7:0] err_seen_ff;
   int errors = 0;
   int num_checks = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   ssr_regs ssr_regs_i(.clk(clk), .rst(rst), .meas(meas), .inst_state(inst_state), .remote_on(remote_on),
      .fb_clear_restart(fb_clear_restart), .req(req), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff),
      .err_seen_ff(err_seen_ff), .restart_ff(restart_ff));
   ssr_master_model ssr_master_model_i(.clk(clk), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff), .req(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
   endtask
   // Restart flag across fieldbus, TCP, RTU and the clear command
   task automatic t_restart();
      chk({31'h0, restart_ff}, 32'h1);
      ssr_master_model_i.rd(SSR_IDX_INST_STATUS, SSR_SRC_FIELDBUS, 1'b0, d);
      chk(d, 32'h2);
      chk({31'h0, restart_ff}, 32'h1);
      @(posedge clk) remote_on <= 1'b1;
      ssr_master_model_i.rd(SSR_IDX_INST_STATUS, SSR_SRC_TCP, 1'b0, d);
      chk(d, 32'h3);
      ssr_master_model_i.rd(SSR_IDX_INST_STATUS, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h1);
      do_reset();
      ssr_master_model_i.rd(SSR_IDX_INST_STATUS, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h3);
      chk({31'h0, restart_ff}, 32'h0);
      do_reset();
      @(posedge clk) fb_clear_restart <= 1'b1;
      @(posedge clk) fb_clear_restart <= 1'b0;
      #1 chk({31'h0, restart_ff}, 32'h0);
   endtask
   // Scale status bits, error code, input signal, state, spare index
   task automatic t_scale();
      @(posedge clk) meas <= '{gross: 32'h1E_8480, net: 32'h9C40, flow: 32'hFFFF_7FFF, input_uvv: 32'h5DC,
         error_code: 8'hFF, zero_disp: 1'b1, zero_gross: 1'b0, zero_net: 1'b1, net_mode: 1'b1, motion: 1'b1,
         flow_disp: 1'b1};
      inst_state <= SSR_ST_POWER_FAIL;
      ssr_master_model_i.rd(SSR_IDX_SCALE_STATUS, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h28EF);
      ssr_master_model_i.rd(SSR_IDX_SCALE_STATUS, SSR_SRC_TCP, 1'b1, d);
      chk(d, 32'h28E8);
      ssr_master_model_i.rd(SSR_IDX_SCALE_ERROR, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'hFF);
      chk({31'h0, ssr_master_model_i.trust(err_seen_ff)}, 32'h0);
      ssr_master_model_i.rd(SSR_IDX_INPUT_SIG, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h5DC);
      ssr_master_model_i.rd(SSR_IDX_INST_STATE, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h6);
      @(posedge clk) meas <= '{gross: 32'h7FFF, net: 32'hFFF0_BDC0, flow: 32'hFFFF_8000, default: '0};
      ssr_master_model_i.rd(SSR_IDX_SCALE_STATUS, SSR_SRC_FIELDBUS, 1'b0, d);
      chk(d, 32'h1001);
      chk({31'h0, ssr_master_model_i.trust(err_seen_ff)}, 32'h1);
      chk({24'h0, err_seen_ff}, 32'h0);
      ssr_master_model_i.rd(4'h9, SSR_SRC_RTU, 1'b0, d);
      chk(d, 32'h0);
   endtask
   // Main sequence
   initial begin
      do_reset();
      t_restart();
      t_scale();
      finish_test();
   end
   // Watchdog far past the expected run
   initial begin
      #100000;
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
